// ### elt_cfg.svh
// Overview of operation
// - 16-bit up/down counter, compare and capture registers
// - eight selectable count clock sources
// - compare match drives pin low/high/toggle
// - capture on rising, falling or both edges
// - pwm period and duty from general registers
// - phase counting counts up or down
// - overflow, underflow, match, capture interrupt sources
// - clear on match a sets period
// - software may write the counter directly
// - event operation: start, count, or capture
// - event sets count_run; ignored when already set
// - event counting overrides prescaler, counts exactly
// - event capture copies counter into register b
// - compare match a goes out as event
// - counter and registers accessed as 16-bit words
`ifndef ELT_CFG_SVH
`define ELT_CFG_SVH

`define ELT_WIDTH 16
`define ELT_COUNT_RESET 16'h0000
`define ELT_COUNT_MAX 16'hffff
`define ELT_GRA_RESET 16'hffff
`define ELT_GRB_RESET 16'hffff

// clock_prescale_select codes
`define ELT_CLK_DIV1 3'h0
`define ELT_CLK_DIV2 3'h1
`define ELT_CLK_DIV4 3'h2
`define ELT_CLK_DIV8 3'h3
`define ELT_CLK_DIV32 3'h4
`define ELT_CLK_DIV40 3'h5
`define ELT_CLK_EXTA 3'h6
`define ELT_CLK_EXTB 3'h7
`define ELT_DIV40_LAST 6'h27

// io_action codes; bit 2 selects capture
`define ELT_IO_CAPTURE_BIT 2
`define ELT_IO_OFF 3'h0
`define ELT_IO_LOW 3'h1
`define ELT_IO_HIGH 3'h2
`define ELT_IO_TOGGLE 3'h3
`define ELT_IO_CAP_RISE 2'h0
`define ELT_IO_CAP_FALL 2'h1

`endif

// ### elt_chk.sv
`timescale 1ns/1ps
module elt_chk (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // configuration and strobes
   input wire logic [1:0] mode_i,
   input wire logic clear_on_match_a_i,
   input wire logic [2:0] io_action_a_i,
   input wire logic [1:0] event_op_select_i,
   input wire logic count_wr_i,
   input wire logic compare_a_wr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic event_i,
   // outputs
   input wire logic count_run_o,
   input wire logic [15:0] timer_count_o,
   input wire logic [15:0] general_compare_a_o,
   input wire logic [15:0] general_capture_b_o,
   input wire logic event_match_a_o,
   input wire logic irq_match_a_o,
   input wire logic irq_capture_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic step;
   logic hit;
   // event-driven step and a clearing match
   assign step = event_i && count_run_o && event_op_select_i == 2'h2 && mode_i == 2'h0
      && !count_wr_i;
   assign hit = clear_on_match_a_i && !io_action_a_i[2] && timer_count_o == general_compare_a_o;
   match_single_a: assert property (
      event_match_a_o |=> !event_match_a_o) else $error("match pulse too long");
   match_irq_a: assert property (
      irq_match_a_o == event_match_a_o) else $error("match event and irq differ");
   count_write_a: assert property (
      count_wr_i |=> timer_count_o == $past(wr_data_i)) else $error("counter write lost");
   gra_write_a: assert property (
      compare_a_wr_i && !io_action_a_i[2] |=> general_compare_a_o == $past(wr_data_i))
      else $error("compare a write lost");
   event_start_a: assert property (
      event_i && event_op_select_i == 2'h1 && !count_run_o |=> count_run_o)
      else $error("event start missed");
   event_count_a: assert property (
      step && !hit |=> timer_count_o == $past(timer_count_o) + 16'h1)
      else $error("event count wrong");
   match_clear_a: assert property (
      step && hit |=> timer_count_o == 16'h0 && event_match_a_o) else $error("no clear");
   event_capture_a: assert property (
      event_i && event_op_select_i == 2'h3 |=>
      general_capture_b_o == $past(timer_count_o) && irq_capture_o) else $error("no capture");
   cover property (step && hit);
   cover property (event_i && event_op_select_i == 2'h3);
   cover property (event_i && event_op_select_i == 2'h1 && !count_run_o);
endmodule
bind elt_timer elt_chk elt_chk_i (.core_clk_i, .sys_rst_i, .mode_i, .clear_on_match_a_i,
   .io_action_a_i, .event_op_select_i, .count_wr_i, .compare_a_wr_i, .wr_data_i, .event_i,
   .count_run_o, .timer_count_o, .general_compare_a_o, .general_capture_b_o,
   .event_match_a_o, .irq_match_a_o, .irq_capture_o);

// ### elt_link_model.sv
`timescale 1ns/1ps
module elt_link_model (
   // clock
   input wire logic core_clk_i,
   // bench control
   input wire logic fire_i,
   input wire logic spin_i,
   input wire logic dir_i,
   // timer side
   output logic event_o,
   output logic external_clock_a_o,
   output logic external_clock_b_o
);
   logic [1:0] ph;
   logic [1:0] q;
   initial begin
      event_o = 1'b0;
      ph = 2'h0;
      q = 2'h0;
   end
   // one high cycle per event; clocks stand still unless spinning
   always @(negedge core_clk_i) begin
      event_o <= fire_i;
      if (spin_i) begin
         ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
         if (ph == 2'h2)
            q <= dir_i ? q - 2'h1 : q + 2'h1;
      end
   end
   // quadrature pair, a leads while dir_i is high
   assign external_clock_a_o = q[1];
   assign external_clock_b_o = q[1] ^ q[0];
endmodule

// ### elt_pkg.sv
package elt_pkg;

   typedef enum logic [1:0] {
      ELT_MODE_TIMER,
      ELT_MODE_PWM,
      ELT_MODE_PHASE,
      ELT_MODE_RSVD
   } elt_mode_t;

   typedef enum logic [1:0] {
      ELT_EVOP_NONE,
      ELT_EVOP_START,
      ELT_EVOP_COUNT,
      ELT_EVOP_CAPTURE
   } elt_evop_t;

endpackage

// ### elt_prescale.sv
`timescale 1ns/1ps
`include "elt_cfg.svh"

module elt_prescale (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // selection
   input wire logic [2:0] clock_prescale_select_i,
   // external clocks
   input wire logic external_clock_a_i,
   input wire logic external_clock_b_i,
   // count enable
   output logic tick_o
);

   logic [4:0] div_cnt;
   logic [5:0] div40_cnt;
   logic ext_a_q;
   logic ext_b_q;
   logic next_tick;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         div40_cnt <= 6'h00;
      end else if (div40_cnt == `ELT_DIV40_LAST) begin
         div40_cnt <= 6'h00;
      end else begin
         div40_cnt <= div40_cnt + 6'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ext_a_q <= 1'b0;
         ext_b_q <= 1'b0;
      end else begin
         ext_a_q <= external_clock_a_i;
         ext_b_q <= external_clock_b_i;
      end
   end

   // one enable pulse per divided period or external rising edge
   always_comb begin
      case (clock_prescale_select_i)
         `ELT_CLK_DIV1: next_tick = 1'b1;
         `ELT_CLK_DIV2: next_tick = div_cnt[0];
         `ELT_CLK_DIV4: next_tick = &div_cnt[1:0];
         `ELT_CLK_DIV8: next_tick = &div_cnt[2:0];
         `ELT_CLK_DIV32: next_tick = &div_cnt;
         `ELT_CLK_DIV40: next_tick = (div40_cnt == `ELT_DIV40_LAST);
         `ELT_CLK_EXTA: next_tick = external_clock_a_i & ~ext_a_q;
         default: next_tick = external_clock_b_i & ~ext_b_q;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= next_tick;
      end
   end

endmodule

// ### elt_timer.sv
`timescale 1ns/1ps
`include "elt_cfg.svh"

module elt_timer (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // configuration
   input wire logic [1:0] mode_i,
   input wire logic [2:0] clock_prescale_select_i,
   input wire logic clear_on_match_a_i,
   input wire logic [2:0] io_action_a_i,
   input wire logic [2:0] io_action_b_i,
   input wire logic [1:0] event_op_select_i,
   // software access
   input wire logic count_run_wr_i,
   input wire logic count_run_data_i,
   input wire logic count_wr_i,
   input wire logic compare_a_wr_i,
   input wire logic capture_b_wr_i,
   input wire logic [15:0] wr_data_i,
   // event link
   input wire logic event_i,
   // pins
   input wire logic external_clock_a_i,
   input wire logic external_clock_b_i,
   input wire logic capture_a_pin_i,
   input wire logic capture_b_pin_i,
   // status and registers
   output logic count_run_o,
   output logic [15:0] timer_count_o,
   output logic [15:0] general_compare_a_o,
   output logic [15:0] general_capture_b_o,
   // pin outputs
   output logic compare_a_pin_o,
   output logic compare_a_oe_o,
   output logic compare_b_pin_o,
   output logic compare_b_oe_o,
   // events and interrupts
   output logic event_match_a_o,
   output logic irq_overflow_o,
   output logic irq_underflow_o,
   output logic irq_match_a_o,
   output logic irq_match_b_o,
   output logic irq_capture_o
);

   // selected edge of a capture input
   function automatic logic cap_edge(input logic cur, input logic prev,
                                     input logic [1:0] sel);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      case (sel)
         `ELT_IO_CAP_RISE: cap_edge = rise;
         `ELT_IO_CAP_FALL: cap_edge = fall;
         default: cap_edge = rise | fall;
      endcase
   endfunction

   // pin level after a compare match
   function automatic logic match_action(input logic [2:0] act, input logic cur);
      case (act)
         `ELT_IO_LOW: match_action = 1'b0;
         `ELT_IO_HIGH: match_action = 1'b1;
         `ELT_IO_TOGGLE: match_action = ~cur;
         default: match_action = cur;
      endcase
   endfunction

   // channel set to capture while in timer mode
   function automatic logic chan_captures(input elt_pkg::elt_mode_t md, input logic [2:0] act);
      chan_captures = (md == elt_pkg::ELT_MODE_TIMER) & act[`ELT_IO_CAPTURE_BIT];
   endfunction

   // pin driven by a compare action
   function automatic logic chan_drives(input logic [2:0] act);
      chan_drives = ~act[`ELT_IO_CAPTURE_BIT] & (act != `ELT_IO_OFF);
   endfunction

   elt_pkg::elt_mode_t mode;
   elt_pkg::elt_evop_t evop;

   logic presc_tick;
   logic ext_a_q;
   logic ext_b_q;
   logic cap_a_q;
   logic cap_b_q;
   logic step;
   logic up;
   logic run_step;
   logic match_a;
   logic match_b;
   logic clear_a;
   logic overflow;
   logic underflow;
   logic a_cap_mode;
   logic b_cap_mode;
   logic pin_cap_a;
   logic pin_cap_b;
   logic ev_cap_b;
   logic phase_a_chg;
   logic phase_b_chg;
   logic [15:0] next_count;

   assign mode = elt_pkg::elt_mode_t'(mode_i);
   assign evop = elt_pkg::elt_evop_t'(event_op_select_i);
   assign a_cap_mode = chan_captures(mode, io_action_a_i);
   assign b_cap_mode = chan_captures(mode, io_action_b_i);

   elt_prescale u_prescale (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .clock_prescale_select_i(clock_prescale_select_i),
      .external_clock_a_i(external_clock_a_i),
      .external_clock_b_i(external_clock_b_i),
      .tick_o(presc_tick)
   );

   // previous external clock levels for phase detection
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ext_a_q <= 1'b0;
         ext_b_q <= 1'b0;
      end else begin
         ext_a_q <= external_clock_a_i;
         ext_b_q <= external_clock_b_i;
      end
   end

   // previous capture pin levels for edge detection
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cap_a_q <= 1'b0;
         cap_b_q <= 1'b0;
      end else begin
         cap_a_q <= capture_a_pin_i;
         cap_b_q <= capture_b_pin_i;
      end
   end

   assign phase_a_chg = external_clock_a_i ^ ext_a_q;
   assign phase_b_chg = external_clock_b_i ^ ext_b_q;

   // count step source and direction
   always_comb begin
      if (mode == elt_pkg::ELT_MODE_PHASE) begin
         step = phase_a_chg ^ phase_b_chg;
         up = external_clock_a_i ^ ext_b_q;
      end else if (evop == elt_pkg::ELT_EVOP_COUNT) begin
         step = event_i;
         up = 1'b1;
      end else begin
         step = presc_tick;
         up = 1'b1;
      end
   end

   assign run_step = count_run_o & step;
   assign match_a = run_step & (timer_count_o == general_compare_a_o)
                    & ~a_cap_mode;
   assign match_b = run_step & (timer_count_o == general_capture_b_o)
                    & ~b_cap_mode;
   assign clear_a = match_a & up & ((mode == elt_pkg::ELT_MODE_PWM)
                    | (mode == elt_pkg::ELT_MODE_TIMER & clear_on_match_a_i));
   assign overflow = run_step & up & ~clear_a
                     & (timer_count_o == `ELT_COUNT_MAX);
   assign underflow = run_step & ~up
                      & (timer_count_o == `ELT_COUNT_RESET);

   // capture sources
   assign pin_cap_a = a_cap_mode
                      & cap_edge(capture_a_pin_i, cap_a_q, io_action_a_i[1:0]);
   assign pin_cap_b = b_cap_mode
                      & cap_edge(capture_b_pin_i, cap_b_q, io_action_b_i[1:0]);
   assign ev_cap_b = (evop == elt_pkg::ELT_EVOP_CAPTURE) & event_i;

   // counter next value; a software write wins over counting
   always_comb begin
      if (count_wr_i) begin
         next_count = wr_data_i;
      end else if (clear_a) begin
         next_count = `ELT_COUNT_RESET;
      end else if (run_step & up) begin
         next_count = timer_count_o + 16'h0001;
      end else if (run_step) begin
         next_count = timer_count_o - 16'h0001;
      end else begin
         next_count = timer_count_o;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         timer_count_o <= `ELT_COUNT_RESET;
      end else begin
         timer_count_o <= next_count;
      end
   end

   // run bit: an event start only acts while the bit is clear
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         count_run_o <= 1'b0;
      end else if (evop == elt_pkg::ELT_EVOP_START & event_i & ~count_run_o) begin
         count_run_o <= 1'b1;
      end else if (count_run_wr_i) begin
         count_run_o <= count_run_data_i;
      end
   end

   // register a: compare value or pin capture
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         general_compare_a_o <= `ELT_GRA_RESET;
      end else if (pin_cap_a) begin
         general_compare_a_o <= timer_count_o;
      end else if (compare_a_wr_i) begin
         general_compare_a_o <= wr_data_i;
      end
   end

   // register b: compare value, pin or event capture
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         general_capture_b_o <= `ELT_GRB_RESET;
      end else if (ev_cap_b | pin_cap_b) begin
         general_capture_b_o <= timer_count_o;
      end else if (capture_b_wr_i) begin
         general_capture_b_o <= wr_data_i;
      end
   end

   // pin a drive enable
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         compare_a_oe_o <= 1'b0;
      end else if (mode == elt_pkg::ELT_MODE_PWM) begin
         compare_a_oe_o <= 1'b1;
      end else if (mode == elt_pkg::ELT_MODE_TIMER) begin
         compare_a_oe_o <= chan_drives(io_action_a_i);
      end else begin
         compare_a_oe_o <= 1'b0;
      end
   end

   // pin a level: pwm waveform or compare action
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         compare_a_pin_o <= 1'b0;
      end else if (mode == elt_pkg::ELT_MODE_PWM) begin
         if (match_a) begin
            compare_a_pin_o <= 1'b1;
         end else if (match_b) begin
            compare_a_pin_o <= 1'b0;
         end
      end else if ((mode == elt_pkg::ELT_MODE_TIMER) & match_a) begin
         compare_a_pin_o <= match_action(io_action_a_i, compare_a_pin_o);
      end
   end

   // pin b drive enable, timer mode only
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         compare_b_oe_o <= 1'b0;
      end else if (mode == elt_pkg::ELT_MODE_TIMER) begin
         compare_b_oe_o <= chan_drives(io_action_b_i);
      end else begin
         compare_b_oe_o <= 1'b0;
      end
   end

   // pin b level: compare action in timer mode only
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         compare_b_pin_o <= 1'b0;
      end else if ((mode == elt_pkg::ELT_MODE_TIMER) & match_b) begin
         compare_b_pin_o <= match_action(io_action_b_i, compare_b_pin_o);
      end
   end

   // one-cycle event and interrupt pulses
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         event_match_a_o <= 1'b0;
         irq_match_a_o <= 1'b0;
      end else begin
         event_match_a_o <= match_a;
         irq_match_a_o <= match_a;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         irq_overflow_o <= 1'b0;
         irq_underflow_o <= 1'b0;
         irq_match_b_o <= 1'b0;
         irq_capture_o <= 1'b0;
      end else begin
         irq_overflow_o <= overflow;
         irq_underflow_o <= underflow;
         irq_match_b_o <= match_b;
         irq_capture_o <= pin_cap_a | pin_cap_b | ev_cap_b;
      end
   end

endmodule

// ### event_linked_timer_tb.sv
`timescale 1ns/1ps
module event_linked_timer_tb;
   logic core_clk_i, sys_rst_i, clear_on_match_a_i, count_run_wr_i, count_run_data_i;
   logic count_wr_i, compare_a_wr_i, capture_b_wr_i, capture_a_pin_i, capture_b_pin_i;
   logic event_i, external_clock_a_i, external_clock_b_i, fire, spin, dir, p;
   logic [1:0] mode_i, event_op_select_i;
   logic [2:0] clock_prescale_select_i, io_action_a_i, io_action_b_i;
   logic [15:0] wr_data_i, timer_count_o, general_compare_a_o, general_capture_b_o, d, c, o;
   logic count_run_o, compare_a_pin_o, compare_a_oe_o, event_match_a_o;
   logic compare_b_pin_o, compare_b_oe_o, irq_match_b_o, pb;
   logic irq_overflow_o, irq_underflow_o, irq_match_a_o, irq_capture_o;
   logic [31:0] lf;
   logic [15:0] dv [8] = '{16'h1, 16'h2, 16'h4, 16'h8, 16'h20, 16'h28, 16'hc, 16'hc};
   int n_fail, comparisons, n, k;
   elt_timer elt_timer_i (.core_clk_i, .sys_rst_i, .mode_i, .clock_prescale_select_i,
      .clear_on_match_a_i, .io_action_a_i, .io_action_b_i, .event_op_select_i,
      .count_run_wr_i, .count_run_data_i, .count_wr_i, .compare_a_wr_i, .capture_b_wr_i,
      .wr_data_i, .event_i, .external_clock_a_i, .external_clock_b_i, .capture_a_pin_i,
      .capture_b_pin_i, .count_run_o, .timer_count_o, .general_compare_a_o,
      .general_capture_b_o, .compare_a_pin_o, .compare_a_oe_o, .compare_b_pin_o,
      .compare_b_oe_o, .event_match_a_o, .irq_overflow_o, .irq_underflow_o,
      .irq_match_a_o, .irq_match_b_o, .irq_capture_o);
   elt_link_model elt_link_model_i (.core_clk_i, .fire_i(fire), .spin_i(spin), .dir_i(dir),
      .event_o(event_i), .external_clock_a_o(external_clock_a_i),
      .external_clock_b_o(external_clock_b_i));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic cap(input int a, input logic q);
      return a == 6 || (a == 4) == q;
   endfunction
   function automatic logic act(input int a, input logic q);
      return a == 2 || (a == 3 && !q);
   endfunction
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int m);
      repeat (m) @(negedge core_clk_i);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rnd;
      lf = lfsr(lf);
      d = lf[15:0];
   endtask
   // w: 0 counter, 1 compare a, 2 capture b, 3 run bit
   task automatic wr(input int w, input logic [15:0] v);
      wr_data_i = v;
      count_wr_i = w == 0;
      compare_a_wr_i = w == 1;
      capture_b_wr_i = w == 2;
      count_run_wr_i = w == 3;
      count_run_data_i = v[0];
      cyc(1);
      {count_wr_i, compare_a_wr_i, capture_b_wr_i, count_run_wr_i} = 4'h0;
      cyc(1);
   endtask
   // c: counter value at the edge that takes the event
   task automatic ev(output logic [15:0] cv);
      fire <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      cv = timer_count_o;
      cyc(1);
   endtask
   // m=0: cycles to next counter change, m=1: cycles to next match pulse
   task automatic gap(input bit m, output int g);
      logic [15:0] s;
      s = timer_count_o;
      g = 0;
      do begin
         cyc(1);
         g++;
      end while ((m ? event_match_a_o !== 1'b1 : timer_count_o === s) && g < 100);
      if (g >= 100) begin
         n_fail++;
         end_sim;
      end
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   initial begin
      lf = 32'hddec2e5c;
      {mode_i, event_op_select_i, clock_prescale_select_i, io_action_a_i, io_action_b_i} = '0;
      {clear_on_match_a_i, count_run_wr_i, count_run_data_i, count_wr_i} = 4'h0;
      {compare_a_wr_i, capture_b_wr_i, capture_a_pin_i} = 3'h0;
      capture_b_pin_i = 1'b0;
      {fire, spin, dir} = 3'h0;
      wr_data_i = 16'h0;
      sys_rst_i = 1'b1;
      cyc(5);
      sys_rst_i = 1'b0;
      chk(timer_count_o, 16'h0);
      chk(general_compare_a_o, 16'hffff);
      chk(general_capture_b_o, 16'hffff);
      chk(16'(count_run_o), 16'h0);
      repeat (4) begin
         rnd;
         wr(1, d);
         chk(general_compare_a_o, d);
         wr(2, ~d);
         chk(general_capture_b_o, ~d);
         wr(0, d ^ 16'h5a5a);
         chk(timer_count_o, d ^ 16'h5a5a);
      end
      wr(1, 16'hffff);
      wr(3, 16'h1);
      spin <= 1'b1;
      for (int s = 0; s < 8; s++) begin
         clock_prescale_select_i = 3'(s);
         gap(0, n);
         gap(0, n);
         chk(16'(n), dv[s]);
      end
      spin <= 1'b0;
      $display("test prescale done");
      clock_prescale_select_i = 3'h0;
      clear_on_match_a_i = 1'b1;
      rnd;
      d = {12'h0, d[3:0]} + 16'h2;
      wr(1, d);
      wr(2, d);
      wr(0, 16'h0);
      for (int a = 1; a < 4; a++) begin
         io_action_a_i = 3'(a);
         io_action_b_i = 3'(a);
         gap(1, n);
         p = compare_a_pin_o;
         pb = compare_b_pin_o;
         gap(1, n);
         chk(16'(n), d + 16'h1);
         chk(16'({compare_a_oe_o, compare_a_pin_o}), 16'({1'b1, act(a, p)}));
         chk(16'({compare_b_oe_o, compare_b_pin_o}), 16'({1'b1, act(a, pb)}));
         chk(16'(irq_match_b_o), 16'h1);
      end
      clear_on_match_a_i = 1'b0;
      for (int a = 4; a < 7; a++) begin
         io_action_a_i = 3'(a);
         repeat (2) begin
            o = general_compare_a_o;
            capture_a_pin_i = !capture_a_pin_i;
            c = timer_count_o;
            cyc(1);
            chk(general_compare_a_o, cap(a, capture_a_pin_i) ? c : o);
         end
      end
      $display("test compare done");
      io_action_a_i = 3'h0;
      event_op_select_i = 2'h1;
      wr(3, 16'h0);
      ev(c);
      chk(16'(count_run_o), 16'h1);
      ev(c);
      chk(16'(count_run_o), 16'h1);
      event_op_select_i = 2'h2;
      clear_on_match_a_i = 1'b1;
      wr(1, 16'h5);
      wr(0, 16'h0);
      rnd;
      k = int'(d[3:0]) + 1;
      repeat (k) begin
         ev(c);
         cyc(int'(d[5:4]));
      end
      chk(timer_count_o, 16'(k % 6));
      clear_on_match_a_i = 1'b0;
      wr(0, 16'hffff);
      ev(c);
      chk(16'({irq_overflow_o, timer_count_o[14:0]}), 16'h8000);
      io_action_b_i = 3'h5;
      event_op_select_i = 2'h3;
      repeat (3) begin
         ev(c);
         chk(general_capture_b_o, c);
         chk(16'(irq_capture_o), 16'h1);
      end
      $display("test event done");
      {event_op_select_i, io_action_b_i} = 5'h0;
      mode_i = 2'h1;
      wr(0, 16'h0);
      wr(1, 16'h9);
      rnd;
      wr(2, {13'h0, d[2:0]});
      gap(1, n);
      n = 0;
      repeat (10) begin
         cyc(1);
         n += int'(compare_a_pin_o);
      end
      chk(16'(n), {13'h0, d[2:0]} + 16'h1);
      mode_i = 2'h2;
      spin <= 1'b1;
      wr(0, 16'h0);
      n = 0;
      while (irq_underflow_o !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      if (irq_underflow_o !== 1'b1) begin
         n_fail++;
         end_sim;
      end
      chk(16'(irq_underflow_o), 16'h1);
      dir <= 1'b1;
      wr(0, 16'h100);
      cyc(30);
      chk(16'(timer_count_o > 16'h100), 16'h1);
      spin <= 1'b0;
      $display("test pwm and phase done");
      end_sim;
   end
endmodule
